// [core/rot_comp.sv]
// Reversal and overshoot torque compensation for one feed axis
// ----------------------------------------------------------------------
// Operating notes
// ----------------------------------------------------------------------
// Register bus
//   Zero wait states: the address phase is taken on the edge where
//   hsel, hready and a NONSEQ transfer meet, and the write lands on the
//   following edge from hwdata.
//   Read data is captured in the address phase and stands in hrdata
//   until the next address phase is taken, so a slow master still
//   sees a stable word.
//   Unmapped or unaligned addresses read zero and swallow writes; the
//   response is always OKAY, so software gets no error for a bad
//   offset and must check what it wrote by reading it back.
//   Each register but the status word sits in bits 15:0 of its word; bits 31:16 read zero.
//   The status word packs the pulse flags, the direction memory and
//   the last torque so that a monitor can follow the axis.
//
// Servo cycle
//   All compensation state moves only on the tick strobe; between
//   ticks the torque output is frozen.
//   The torque produced on a tick is built from the inputs present in
//   that cycle and the state from before it, so a reversal seen on a
//   tick shows up as torque on the next tick.
//   Commands are level inputs and are assumed stable around the tick.
//
// Direction memory
//   The last nonzero command sign is kept; zero commands leave it
//   alone, so a stop between two moves in opposite directions still
//   counts as a reversal when motion resumes.
//   Nothing is remembered until the first nonzero command after reset,
//   so the first move never fires a pulse.
//
// Reversal pulse
//   The pulse lasts a fixed number of ticks set by a parameter; a
//   longer pulse helps slow feeds but overlaps fast back-and-forth
//   motion, where a new reversal simply restarts the pulse.
//   The spring term grows with the travel since the reversal and
//   eats into the pulse, and the result never changes sign: it is
//   clamped at zero rather than pushing against the new motion.
//   The viscous term scales with speed, so it is fixed when the pulse
//   starts; the path delay term is applied live on every tick.
//   The unbalance offset joins only the older method; the newer one
//   ignores it by design.
//   An amount of all ones is the suppress code, not a large torque;
//   it is tested before any scaling.
//
// Overshoot
//   Applied only while the command is zero and only when the model
//   droop points against the previous motion and lies outside the
//   dead band.
//   The band is compared as a magnitude; a code of zero gives no band.
//   The two prohibited field codes behave as stop, which is the safe
//   reading of a bad setting.
//   With both amounts zero nothing is applied.
//
// Direction swap
//   The swap bit exchanges only which amount serves which direction;
//   the sign of the torque always follows the command itself.
//
// Units
//   The unit bit is shared by both paths, so changing it rescales
//   every amount at once; software should rewrite the amounts in the
//   new unit before enabling compensation again.
//   Products are kept in 32 bits and cut to the 24-bit torque range;
//   amounts beyond the documented ranges are not clamped here.
//
// Hazards
//   Changing the type bits so that neither type is selected while a pulse runs stops the pulse at the
//   next tick, which can leave a short torque step on the axis.
//   The reversal timing setting is not implemented and is expected to
//   stay at zero on the controller side.
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module rot_comp
  import rot_pkg::*;
#(
  parameter logic [7:0] HOLD_TICKS = HOLD_TICKS_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic servo_tick,
  input wire logic signed [15:0] cmd_velocity,
  input wire logic signed [15:0] model_droop,
  input wire logic signed [15:0] path_delay,
  input wire logic signed [15:0] unbalance_torque_offset,
  output logic signed [23:0] torque_comp,
  output logic reversal_active,
  output logic overshoot_active
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rev_a;
    logic [15:0] rev_b;
    logic [15:0] sf_five;
    logic [15:0] spring;
    logic [15:0] viscous;
    logic [15:0] gain;
    logic [15:0] osh_a;
    logic [15:0] osh_b;
    logic [15:0] sf_one;
    logic [15:0] sf_three;
    logic [15:0] ctrl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic dir_valid;
    logic dir_neg;
    logic [7:0] hold_left;
    logic rev_neg;
    logic [23:0] rev_mag;
    logic [23:0] travel;
    logic signed [23:0] torque;
    logic rev_on;
    logic osh_on;
  } rot_state_s;

  rot_state_s state_reg;
  rot_state_s state_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Amount to hundredths of stall current
  function automatic logic [23:0] to_hundredths(input logic [15:0] amt,
                                                input logic fine);
    logic [31:0] wide;
    wide = {16'h0000, amt};
    if (!fine) begin
      wide = wide * PCT_TO_HUNDREDTHS;
    end
    return wide[23:0];
  endfunction

  // Magnitude of a signed word
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Register read decode
  function automatic logic [31:0] read_word(input rot_state_s s,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      OFS_REV_AMT_A: w = {16'h0000, s.rev_a};
      OFS_REV_AMT_B: w = {16'h0000, s.rev_b};
      OFS_SF_FIVE: w = {16'h0000, s.sf_five};
      OFS_SPRING: w = {16'h0000, s.spring};
      OFS_VISCOUS: w = {16'h0000, s.viscous};
      OFS_PATH_GAIN: w = {16'h0000, s.gain};
      OFS_OSH_AMT_A: w = {16'h0000, s.osh_a};
      OFS_OSH_AMT_B: w = {16'h0000, s.osh_b};
      OFS_SF_ONE: w = {16'h0000, s.sf_one};
      OFS_SF_THREE: w = {16'h0000, s.sf_three};
      OFS_CTRL: w = {16'h0000, s.ctrl};
      OFS_STATUS: w = {4'h0, s.rev_on, s.osh_on, s.dir_valid, s.dir_neg,
                       s.torque};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic addr_ok;
  logic vel_nz;
  logic vel_neg;
  logic phys_neg;
  logic prev_neg;
  logic reversal;
  logic type2;
  logic type3;
  logic fine;
  logic [15:0] rev_sel;
  logic [15:0] osh_sel;
  logic [15:0] vel_mag;
  logic [15:0] droop_mag;
  logic [15:0] band_um;
  logic [31:0] visc_term;
  logic [31:0] spring_term;
  logic signed [31:0] gain_term;
  logic signed [31:0] rev_eff;
  logic [23:0] base;
  logic [23:0] start_mag;
  logic osh_apply;
  logic [23:0] osh_amt;
  logic signed [23:0] rev_torque;
  logic signed [23:0] osh_torque;

  // Compute registers, bus and compensation
  always_comb begin
    state_next = state_reg;
    addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00)
              && (haddr[7:0] <= OFS_LAST);
    state_next.ready = 1'b1;
    // Bus write data phase
    state_next.wr_pend = 1'b0;
    if (state_reg.wr_pend) begin
      case (state_reg.wr_addr)
        OFS_REV_AMT_A: state_next.rev_a = hwdata[15:0];
        OFS_REV_AMT_B: state_next.rev_b = hwdata[15:0];
        OFS_SF_FIVE: state_next.sf_five = hwdata[15:0];
        OFS_SPRING: state_next.spring = hwdata[15:0];
        OFS_VISCOUS: state_next.viscous = hwdata[15:0];
        OFS_PATH_GAIN: state_next.gain = hwdata[15:0];
        OFS_OSH_AMT_A: state_next.osh_a = hwdata[15:0];
        OFS_OSH_AMT_B: state_next.osh_b = hwdata[15:0];
        OFS_SF_ONE: state_next.sf_one = hwdata[15:0];
        OFS_SF_THREE: state_next.sf_three = hwdata[15:0];
        OFS_CTRL: state_next.ctrl = hwdata[15:0];
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end
    // Bus address phase
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      state_next.wr_pend = hwrite && addr_ok;
      state_next.wr_addr = haddr[7:0];
      state_next.rdata = addr_ok ? read_word(state_reg, haddr[7:0])
                                 : 32'h0000_0000;
    end

    // Direction and reversal detection
    vel_nz = (cmd_velocity != 16'sh0000);
    vel_neg = cmd_velocity[15];
    vel_mag = mag16(cmd_velocity);
    phys_neg = vel_neg ^ state_reg.ctrl[CTRL_SWAP_BIT];
    prev_neg = state_reg.dir_neg ^ state_reg.ctrl[CTRL_SWAP_BIT];
    reversal = servo_tick && vel_nz && state_reg.dir_valid
               && (vel_neg != state_reg.dir_neg);
    type2 = state_reg.sf_one[SF1_REV_TYPE_LO +: 2] == REV_TYPE_TWO;
    type3 = state_reg.sf_five[SF5_TYPE3_BIT];
    fine = state_reg.sf_five[SF5_UNIT_BIT];

    // Reversal amount by direction
    if (state_reg.rev_b == AMT_ZERO) begin
      rev_sel = state_reg.rev_a;
    end else begin
      rev_sel = phys_neg ? state_reg.rev_b : state_reg.rev_a;
    end
    base = to_hundredths(rev_sel, fine);
    visc_term = 32'(({16'h0000, state_reg.viscous} * {16'h0000, vel_mag})
                >> VISC_SHIFT);
    if (type3) begin
      start_mag = base + visc_term[23:0];
    end else begin
      start_mag = 24'(signed'(base) + 24'(unbalance_torque_offset));
    end

    // Reversal pulse start and decay
    if (servo_tick && state_reg.hold_left != 8'h00) begin
      state_next.hold_left = state_reg.hold_left - 8'h01;
      state_next.travel = state_reg.travel + {8'h00, vel_mag};
    end
    if (reversal && (type2 || type3) && rev_sel != AMT_SUPPRESS) begin
      state_next.hold_left = HOLD_TICKS;
      state_next.rev_neg = vel_neg;
      state_next.rev_mag = start_mag;
      state_next.travel = 24'h000000;
    end
    if (servo_tick && vel_nz) begin
      state_next.dir_valid = 1'b1;
      state_next.dir_neg = vel_neg;
    end

    // Effective reversal torque with spring and path terms
    spring_term = 32'({16'h0000, state_reg.spring}
                  * {8'h00, state_reg.travel}) >> SPRING_SHIFT;
    gain_term = 32'((signed'({16'h0000, state_reg.gain}) * 32'(path_delay))
                >>> GAIN_SHIFT);
    rev_eff = signed'({8'h00, state_reg.rev_mag}) - signed'(spring_term);
    if (type3 && state_reg.gain != AMT_ZERO) begin
      rev_eff = rev_eff + gain_term;
    end
    if (rev_eff < 0) begin
      rev_eff = 32'sh0;
    end
    if (state_reg.hold_left == 8'h00 || !(type2 || type3)) begin
      rev_eff = 32'sh0;
    end
    rev_torque = state_reg.rev_neg ? 24'(-rev_eff) : 24'(rev_eff);

    // Overshoot amount by preceding direction
    if (state_reg.osh_a == AMT_ZERO) begin
      osh_sel = state_reg.osh_b;
    end else if (state_reg.osh_b == AMT_ZERO) begin
      osh_sel = state_reg.osh_a;
    end else begin
      osh_sel = prev_neg ? state_reg.osh_b : state_reg.osh_a;
    end
    osh_amt = to_hundredths(osh_sel, fine);
    droop_mag = mag16(model_droop);
    band_um = {8'h00, 4'h0, state_reg.sf_three[SF3_BAND_LO +: 4]}
              * {10'h000, BAND_STEP_UM};
    osh_apply = (state_reg.sf_one[SF1_OSH_LO +: 2] == OSH_TYPE_THREE)
                && !vel_nz && state_reg.dir_valid
                && osh_sel != AMT_SUPPRESS && osh_sel != AMT_ZERO
                && (model_droop[15] != state_reg.dir_neg)
                && droop_mag > band_um;
    osh_torque = osh_apply ? (state_reg.dir_neg ? signed'(osh_amt)
                                                : 24'(-signed'(osh_amt)))
                           : 24'sh000000;

    // Combined output on each servo cycle
    if (servo_tick) begin
      state_next.torque = rev_torque + osh_torque;
      state_next.rev_on = rev_eff != 32'sh0;
      state_next.osh_on = osh_apply;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // State update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs from state flip-flops; hresp is the constant OKAY
  assign hrdata = state_reg.rdata;
  assign hreadyout = state_reg.ready;
  assign hresp = HRESP_OKAY;
  assign torque_comp = state_reg.torque;
  assign reversal_active = state_reg.rev_on;
  assign overshoot_active = state_reg.osh_on;

endmodule

// [core/rot_pkg.sv]
// Constants and types for the reversal and overshoot torque compensation
package rot_pkg;

  // ----------------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_REV_AMT_A = 8'h00;
  localparam logic [7:0] OFS_REV_AMT_B = 8'h04;
  localparam logic [7:0] OFS_SF_FIVE = 8'h08;
  localparam logic [7:0] OFS_SPRING = 8'h0c;
  localparam logic [7:0] OFS_VISCOUS = 8'h10;
  localparam logic [7:0] OFS_PATH_GAIN = 8'h14;
  localparam logic [7:0] OFS_OSH_AMT_A = 8'h18;
  localparam logic [7:0] OFS_OSH_AMT_B = 8'h1c;
  localparam logic [7:0] OFS_SF_ONE = 8'h20;
  localparam logic [7:0] OFS_SF_THREE = 8'h24;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_LAST = 8'h2c;

  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int SF1_REV_TYPE_LO = 8;
  localparam logic [1:0] REV_TYPE_TWO = 2'b10;
  localparam int SF1_OSH_LO = 10;
  localparam logic [1:0] OSH_STOP = 2'b00;
  localparam logic [1:0] OSH_TYPE_THREE = 2'b11;
  localparam int SF5_TYPE3_BIT = 1;
  localparam int SF5_UNIT_BIT = 2;
  localparam int SF3_BAND_LO = 12;
  localparam int CTRL_SWAP_BIT = 0;

  // ----------------------------------------------------------------------
  // Values and scaling
  // ----------------------------------------------------------------------
  localparam logic [15:0] AMT_SUPPRESS = 16'hffff;
  localparam logic [15:0] AMT_ZERO = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] PCT_TO_HUNDREDTHS = 32'h0000_0064;
  localparam logic [5:0] BAND_STEP_UM = 6'h02;
  localparam int VISC_SHIFT = 10;
  localparam int SPRING_SHIFT = 8;
  localparam int GAIN_SHIFT = 12;
  localparam logic [7:0] HOLD_TICKS_DEF = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY = 2'b00;

endpackage

// [test/rot_cnc_model.sv]
// Command side model: servo ticks and commands
`timescale 1ns/1ns
module rot_cnc_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic signed [15:0] vel_set,
  input wire logic signed [15:0] droop_set,
  output logic servo_tick,
  output logic signed [15:0] cmd_velocity,
  output logic signed [15:0] model_droop
);
  logic [2:0] cnt_reg;
  // Tick every 8 cycles, commands move mid-period
  // Reversal timing setting is never driven, stays zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 3'h0;
      servo_tick <= 1'b0;
      cmd_velocity <= 16'sh0;
      model_droop <= 16'sh0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      servo_tick <= cnt_reg == 3'h6;
      if (cnt_reg == 3'h2) begin
        cmd_velocity <= vel_set;
        model_droop <= droop_set;
      end
    end
  end
endmodule

// [test/rot_comp_assertions.sv]
// Port checks for the compensation block
`timescale 1ns/1ns
module rot_comp_assertions
  import rot_pkg::*;
#(
  parameter logic [7:0] HOLD_TICKS = HOLD_TICKS_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic servo_tick,
  input wire logic signed [15:0] cmd_velocity,
  input wire logic signed [15:0] model_droop,
  input wire logic signed [23:0] torque_comp,
  input wire logic reversal_active,
  input wire logic overshoot_active
);
  logic rd, v_neg, d_neg;
  logic z1_reg, z2_reg, n1_reg, n2_reg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase and sign helpers
  assign rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  assign v_neg = cmd_velocity[15];
  assign d_neg = model_droop[15];
  // Zero and sign of the command at the last two ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      z1_reg <= 1'b0;
      z2_reg <= 1'b0;
      n1_reg <= 1'b0;
      n2_reg <= 1'b0;
    end else if (servo_tick) begin
      z1_reg <= cmd_velocity == 16'sh0;
      z2_reg <= z1_reg;
      n1_reg <= v_neg;
      n2_reg <= n1_reg;
    end
  end
  AST_HOLD: assert property (!servo_tick |=> $stable(torque_comp))
    else $error("torque moved without a tick");
  AST_IDLE: assert property (!reversal_active && !overshoot_active
    |-> torque_comp == 0) else $error("torque without active pulse");
  AST_ZERO_V: assert property ($rose(reversal_active)
    |-> !z2_reg) else $error("zero started");
  AST_MOVING: assert property (servo_tick && cmd_velocity != 0
    |=> !overshoot_active) else $error("overshoot while moving");
  AST_REV_SIGN: assert property ($rose(reversal_active) |->
    torque_comp == 0 || torque_comp[23] == n2_reg)
    else $error("reversal sign wrong");
  AST_OSH_SIGN: assert property ($rose(overshoot_active) |->
    torque_comp == 0 || torque_comp[23] == $past(d_neg))
    else $error("overshoot sign wrong");
  AST_UPPER: assert property (rd && haddr < {24'h0, OFS_LAST}
    |=> hrdata[31:16] == 16'h0) else $error("upper bits set");
  AST_UNMAP: assert property (rd && haddr > {24'h0, OFS_LAST}
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  COV_REV: cover property ($rose(reversal_active));
  COV_OSH: cover property ($rose(overshoot_active));
  COV_UNMAP: cover property (rd && haddr > {24'h0, OFS_LAST});
endmodule

// [test/tb_rot_comp.sv]
// Self-checking bench for the compensation block
`timescale 1ns/1ns
module tb_rot_comp;
  import rot_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'b00, hresp;
  logic hreadyout, tick, rev_on, osh_on;
  logic signed [15:0] cmd_v, droop, v_set = 16'sh0, d_set = 16'sh0;
  logic signed [23:0] torque;
  int num_errors = 0;
  int total_checks = 0;
  rot_comp #(.HOLD_TICKS(8'h04)) i_rot_comp (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .servo_tick(tick), .cmd_velocity(cmd_v), .model_droop(droop),
    .path_delay(16'sh000a), .unbalance_torque_offset(16'sh0032),
    .torque_comp(torque), .reversal_active(rev_on),
    .overshoot_active(osh_on));
  rot_cnc_model i_rot_cnc_model (.hclk(hclk), .hresetn(hresetn),
    .vel_set(v_set), .droop_set(d_set), .servo_tick(tick),
    .cmd_velocity(cmd_v), .model_droop(droop));
  // Clock at 4 ns
  initial begin
    forever #2 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) fail($sformatf("bus %h exp %h", g, e));
  endtask
  task automatic chk_trq(input logic signed [23:0] e, input logic r, o);
    total_checks++;
    if (torque !== e || rev_on !== r || osh_on !== o)
      fail($sformatf("torque %0d exp %0d", torque, e));
  endtask
  // Bounded wait for hready
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 16; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (hreadyout !== 1'b1) begin
      fail("bus timeout");
      stop_test;
    end
  endtask
  // One single AHB transfer, read data into q
  task automatic bus(input logic w, input logic [7:0] a, logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0, d};
    wait_rdy;
    q = hrdata;
  endtask
  // Hold a command through two servo ticks
  task automatic step(input logic signed [15:0] v, d);
    int n;
    int t;
    @(posedge hclk);
    v_set <= v;
    d_set <= d;
    t = 0;
    for (n = 0; n < 40 && t < 2; n++) begin
      @(posedge hclk);
      if (tick === 1'b1) t++;
    end
    #1;
    if (t < 2) begin
      fail("no servo tick");
      stop_test;
    end
  endtask
  task automatic rev(input logic signed [15:0] v, logic signed [23:0] e);
    repeat (3) step(-v, 16'sh0);
    step(v, 16'sh0);
    chk_trq(e, e != 0, 1'b0);
  endtask
  task automatic osh(input logic signed [15:0] v, d, logic signed [23:0] e);
    repeat (2) step(v, 16'sh0);
    step(16'sh0, d);
    chk_trq(e, 1'b0, e != 0);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_SF_ONE, 16'h0);
    chk_word(q, 32'h0);
    chk_word({30'h0, hresp}, {30'h0, HRESP_OKAY});
    bus(1'b1, OFS_VISCOUS, 16'h0400);
    bus(1'b0, OFS_VISCOUS, 16'h0);
    chk_word(q, 32'h0000_0400);
    bus(1'b1, 8'h30, 16'h1234);
    bus(1'b0, 8'h30, 16'h0);
    chk_word(q, 32'h0);
    $display("test registers done");
    bus(1'b1, OFS_REV_AMT_A, 16'h0003);
    bus(1'b1, OFS_PATH_GAIN, 16'h1000);
    bus(1'b1, OFS_SF_FIVE, 16'h0002);
    rev(-16'sd5, -24'sd315);
    bus(1'b1, OFS_REV_AMT_B, 16'h0007);
    rev(-16'sd5, -24'sd715);
    rev(16'sd5, 24'sd315);
    bus(1'b1, OFS_REV_AMT_B, 16'hffff);
    rev(-16'sd5, 24'sd0);
    bus(1'b1, OFS_CTRL, 16'h0001);
    rev(16'sd5, 24'sd0);
    rev(-16'sd5, -24'sd315);
    bus(1'b1, OFS_CTRL, 16'h0000);
    bus(1'b1, OFS_SF_FIVE, 16'h0006);
    bus(1'b1, OFS_REV_AMT_A, 16'h4e20);
    rev(16'sd5, 24'sd20015);
    bus(1'b1, OFS_SF_FIVE, 16'h0004);
    rev(16'sd5, 24'sd0);
    bus(1'b1, OFS_SF_ONE, 16'h0200);
    rev(16'sd5, 24'sd20050);
    $display("test reversal done");
    bus(1'b1, OFS_SF_FIVE, 16'h0000);
    bus(1'b1, OFS_SF_ONE, 16'h0c00);
    bus(1'b1, OFS_SF_THREE, 16'h2000);
    bus(1'b1, OFS_OSH_AMT_A, 16'h0002);
    osh(16'sd5, -16'sd5, -24'sd200);
    osh(16'sd5, -16'sd3, 24'sd0);
    bus(1'b1, OFS_OSH_AMT_B, 16'h0009);
    osh(-16'sd5, 16'sd5, 24'sd900);
    osh(16'sd5, -16'sd5, -24'sd200);
    bus(1'b1, OFS_OSH_AMT_B, 16'hffff);
    osh(-16'sd5, 16'sd5, 24'sd0);
    bus(1'b1, OFS_SF_ONE, 16'h0400);
    osh(16'sd5, -16'sd5, 24'sd0);
    $display("test overshoot done");
    stop_test;
  end
endmodule
bind rot_comp rot_comp_assertions #(.HOLD_TICKS(HOLD_TICKS))
  i_rot_comp_assertions (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .servo_tick(servo_tick), .cmd_velocity(cmd_velocity),
  .model_droop(model_droop), .torque_comp(torque_comp),
  .reversal_active(reversal_active), .overshoot_active(overshoot_active));
